// [pkg/gpm_pkg.sv]
// package: constants, types and state layout of the power-mode controller
package gpm_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ       = 50_000_000;
	localparam int CLK_NS       = 20;
	localparam int MS_NS        = 1_000_000;
	localparam int MS_CYC       = MS_NS / CLK_NS;
	localparam int PER_DLY_MIN  = 3;
	localparam int FIT_DLY_S    = 60;
	localparam int ORB_GOOD_MIN = 5;
	localparam logic [19:0] PER_DLY_MS = 20'(PER_DLY_MIN * 60_000);
	localparam logic [15:0] FIT_MS     = 16'(FIT_DLY_S * 1_000);
	localparam logic [18:0] ORB_MS     = 19'(ORB_GOOD_MIN * 60_000);
	localparam logic [19:0] AD_ON_MS   = 20'h01388;
	localparam logic [19:0] AD_OFF_S   = 20'h03A98;
	localparam logic [19:0] AD_OFF_L   = 20'h0EA60;
	localparam logic [19:0] AD_WAKE_MS = 20'h007D0;
	localparam logic [19:0] AD_WIN     = AD_ON_MS - AD_WAKE_MS;

	// ****************************************************************
	// serial framing and commands
	// ****************************************************************
	localparam logic [2:0] BAUD_RST = 3'h1;
	localparam logic [2:0] BAUD_MAX = 3'h6;
	localparam logic [7:0] CH_DOL  = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_COM  = 8'h2C;
	localparam logic [7:0] CH_0    = 8'h30;
	localparam logic [7:0] CH_9    = 8'h39;
	localparam logic [9:0] C_PWR = 10'h0E1;
	localparam logic [9:0] C_FIT = 10'h106;
	localparam logic [9:0] C_ORB = 10'h365;
	localparam logic [9:0] C_AIC = 10'h11E;
	localparam logic [19:0] PM_FULL = 20'h00000;
	localparam logic [19:0] PM_PBK  = 20'h00001;
	localparam logic [19:0] PM_PSB  = 20'h00002;
	localparam logic [19:0] PM_ASB  = 20'h00008;
	localparam logic [19:0] PM_ABK  = 20'h00009;
	localparam logic [119:0] ACK_TXT = "$PACK001,225,3*";
	localparam logic [4:0] ACK_LAST = 5'h12;
	localparam logic [3:0] AIC_TONES = 4'hC;

	// ****************************************************************
	// registers
	// ****************************************************************
	localparam logic [11:0] R_CTRL = 12'h000;
	localparam logic [11:0] R_STAT = 12'h004;
	localparam logic [11:0] R_CMD  = 12'h008;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {M_FULL, M_PDLY, M_PRUN, M_PSLP, M_AON,
		M_AOFF} gpm_mode_t;
	typedef enum logic [2:0] {P_IDLE, P_HDR, P_ARG, P_CK1, P_CK2}
		gpm_parse_t;

	typedef struct packed {
		logic [1:0]       rx_sync;
		logic [1:0]       psw_sync;
		logic             rx_busy;
		logic [15:0]      rx_cnt;
		logic [3:0]       rx_bit;
		logic [7:0]       rx_sh;
		gpm_parse_t       pst;
		logic [7:0]       ck;
		logic [3:0]       rck;
		logic [9:0]       code;
		logic [2:0]       argn;
		logic [4:0][19:0] arg;
		logic             exec;
		logic [9:0]       last_code;
		logic [15:0]      last_arg;
		gpm_mode_t        mode;
		logic             pbk;
		logic             ext;
		logic             got_fix;
		logic [19:0]      run;
		logic [19:0]      slp;
		logic [19:0]      erun;
		logic [19:0]      eslp;
		logic [15:0]      ms_cnt;
		logic [19:0]      tmr;
		logic             fit_arm;
		logic             fit_act;
		logic [15:0]      fit_ms;
		logic             orb_en;
		logic [18:0]      orb_ms;
		logic             orb_rdy;
		logic             interference_cancellation;
		logic [2:0]       baud;
		logic             tx_act;
		logic [4:0]       tx_idx;
		logic [7:0]       tx_ck;
		logic             tx_busy;
		logic [15:0]      tx_cnt;
		logic [3:0]       tx_bit;
		logic [8:0]       tx_sh;
		logic             txd;
		logic             psw;
		logic             rf_on;
		logic             nmea;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} gpm_state_t;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		case (sel)
			3'h0: return 16'(CLK_HZ / 4800);
			3'h1: return 16'(CLK_HZ / 9600);
			3'h2: return 16'(CLK_HZ / 14400);
			3'h3: return 16'(CLK_HZ / 19200);
			3'h4: return 16'(CLK_HZ / 38400);
			3'h5: return 16'(CLK_HZ / 57600);
			default: return 16'(CLK_HZ / 115200);
		endcase
	endfunction : baud_div

	// {valid, nibble} of an upper-case hex character
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CH_0 && c <= CH_9)
			return {1'b1, c[3:0]};
		if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, 4'(c[3:0] + 4'h9)};
		return 5'h00;
	endfunction : hex_val

	function automatic logic [7:0] hex_chr(input logic [3:0] v);
		return (v < 4'hA) ? 8'(CH_0 + 8'(v)) : 8'(8'h37 + 8'(v));
	endfunction : hex_chr

	function automatic logic [7:0] ack_byte(input logic [4:0] i,
		input logic [7:0] ck);
		logic [119:0] t;
		t = ACK_TXT << {i, 3'b000};
		if (i < 5'h0F)
			return t[119:112];
		if (i == 5'h0F)
			return hex_chr(ck[7:4]);
		if (i == 5'h10)
			return hex_chr(ck[3:0]);
		if (i == 5'h11)
			return 8'h0D;
		return 8'h0A;
	endfunction : ack_byte

endpackage : gpm_pkg

// [core/gpm_ctrl.sv]
// module: power-mode command controller with serial port and apb slave
module gpm_ctrl #(
	parameter int MS_CYCLES = gpm_pkg::MS_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	// serial link
	input  wire logic        uart_rxd,
	output logic             uart_txd,
	// power switch control, open drain
	input  wire logic        pwr_sw_in,
	output logic             pwr_sw_out,
	output logic             pwr_sw_oe,
	// navigation status
	input  wire logic        fix_valid,
	input  wire logic        rtc_valid,
	// feature enables and orbit readiness
	output logic             rf_on,
	output logic             nmea_en,
	output logic             orbit_predict_en,
	output logic             interference_cancellation_en,
	output logic             fitness_duty_cycle_mode,
	output logic             orbit_ready
);

	gpm_pkg::gpm_state_t s;
	gpm_pkg::gpm_state_t n;
	logic [15:0]         div;
	logic                rx_ok;
	logic [7:0]          b;
	logic [4:0]          hv;
	logic                dig;
	logic [19:0]         dv;
	logic                tick;
	logic                fin;
	logic                wake;
	logic                exit_ok;
	logic [19:0]         a0;
	logic [7:0]          tb;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		n = s;
		div = gpm_pkg::baud_div(s.baud);
		rx_ok = 1'b0;
		b = s.rx_sh;
		hv = gpm_pkg::hex_val(s.rx_sh);
		dig = (b >= gpm_pkg::CH_0) && (b <= gpm_pkg::CH_9);
		dv = 20'(b[3:0]);
		a0 = s.arg[0];
		exit_ok = 1'b0;
		tb = gpm_pkg::ack_byte(s.tx_idx, s.tx_ck);

		// receiver: start, 8 data, stop; no handshake lines
		n.rx_sync = {s.rx_sync[0], uart_rxd};
		n.psw_sync = {s.psw_sync[0], pwr_sw_in};
		if (!s.rx_busy)
		begin
			if (!s.rx_sync[1])
			begin
				n.rx_busy = 1'b1;
				n.rx_cnt = {1'b0, div[15:1]};
				n.rx_bit = 4'h0;
			end
		end
		else if (s.rx_cnt != 16'h0000)
			n.rx_cnt = s.rx_cnt - 16'h0001;
		else
		begin
			n.rx_cnt = div - 16'h0001;
			n.rx_bit = s.rx_bit + 4'h1;
			if (s.rx_bit == 4'h0 && s.rx_sync[1])
				n.rx_busy = 1'b0;
			else if (s.rx_bit == 4'h9)
			begin
				n.rx_busy = 1'b0;
				rx_ok = s.rx_sync[1];
			end
			else if (s.rx_bit != 4'h0)
				n.rx_sh = {s.rx_sync[1], s.rx_sh[7:1]};
		end
		wake = rx_ok;

		// sentence parser with xor checksum
		n.exec = 1'b0;
		if (rx_ok)
		begin
			if (b == gpm_pkg::CH_DOL)
			begin
				n.pst = gpm_pkg::P_HDR;
				n.ck = 8'h00;
				n.code = 10'h000;
				n.argn = 3'h0;
				n.arg = '0;
			end
			else
				unique case (s.pst)
					gpm_pkg::P_IDLE:
						n.pst = gpm_pkg::P_IDLE;
					gpm_pkg::P_HDR, gpm_pkg::P_ARG:
						if (b == gpm_pkg::CH_STAR)
							n.pst = gpm_pkg::P_CK1;
						else
						begin
							n.ck = s.ck ^ b;
							if (b == gpm_pkg::CH_COM)
							begin
								n.pst = gpm_pkg::P_ARG;
								if (s.pst == gpm_pkg::P_ARG && s.argn != 3'h4)
									n.argn = s.argn + 3'h1;
							end
							else if (dig && s.pst == gpm_pkg::P_HDR)
								n.code = 10'(s.code * 10'd10 + 10'(b[3:0]));
							else if (dig)
								n.arg[s.argn] = 20'(s.arg[s.argn] * 20'd10 + dv);
						end
					gpm_pkg::P_CK1:
						if (hv[4])
						begin
							n.rck = hv[3:0];
							n.pst = gpm_pkg::P_CK2;
						end
						else
							n.pst = gpm_pkg::P_IDLE;
					gpm_pkg::P_CK2:
					begin
						n.pst = gpm_pkg::P_IDLE;
						n.exec = hv[4] && ({s.rck, hv[3:0]} == s.ck);
					end
				endcase
		end

		// millisecond tick and phase timer
		tick = (s.ms_cnt == 16'h0000);
		n.ms_cnt = tick ? 16'(MS_CYCLES - 1) : s.ms_cnt - 16'h0001;
		fin = tick && (s.tmr == 20'h00000);
		if (tick && s.tmr != 20'h00000)
			n.tmr = s.tmr - 20'h00001;
		if (fix_valid)
			n.got_fix = 1'b1;

		// duty-cycle sequencer
		unique case (s.mode)
			gpm_pkg::M_FULL:
				n.mode = gpm_pkg::M_FULL;
			gpm_pkg::M_PDLY:
				if (fin)
				begin
					n.mode = gpm_pkg::M_PRUN;
					n.tmr = s.run;
					n.got_fix = 1'b0;
				end
			gpm_pkg::M_PRUN:
				if (fin)
				begin
					n.mode = gpm_pkg::M_PSLP;
					n.ext = !s.got_fix;
					n.tmr = !s.got_fix ? s.eslp : s.slp;
				end
			gpm_pkg::M_PSLP:
				if (fin || (wake && !s.pbk))
				begin
					n.mode = gpm_pkg::M_PRUN;
					n.tmr = s.ext ? s.erun : s.run;
					n.got_fix = 1'b0;
				end
			gpm_pkg::M_AON:
				if (fin)
				begin
					n.mode = gpm_pkg::M_AOFF;
					n.tmr = fix_valid ? gpm_pkg::AD_OFF_L : gpm_pkg::AD_OFF_S;
				end
			gpm_pkg::M_AOFF:
				if (fin || (wake && !s.pbk))
				begin
					n.mode = gpm_pkg::M_AON;
					n.tmr = gpm_pkg::AD_ON_MS;
				end
		endcase

		// fitness arming and orbit data readiness
		if (s.fit_arm && !s.fit_act)
		begin
			if (!fix_valid)
				n.fit_ms = 16'h0000;
			else if (tick && s.fit_ms == gpm_pkg::FIT_MS)
				n.fit_act = 1'b1;
			else if (tick)
				n.fit_ms = s.fit_ms + 16'h0001;
		end
		if (!rtc_valid)
		begin
			n.orb_ms = 19'h00000;
			n.orb_rdy = 1'b0;
		end
		else if (tick && fix_valid && !s.orb_rdy)
		begin
			if (s.orb_ms == gpm_pkg::ORB_MS)
				n.orb_rdy = 1'b1;
			else
				n.orb_ms = s.orb_ms + 19'h00001;
		end

		// command execution
		if (s.mode == gpm_pkg::M_AON)
			exit_ok = !s.pbk || (s.tmr >= gpm_pkg::AD_WIN);
		else
			exit_ok = !s.pbk || (s.mode != gpm_pkg::M_PSLP && s.mode != gpm_pkg::M_AOFF);
		if (s.exec)
		begin
			n.last_code = s.code;
			n.last_arg = a0[15:0];
			if (s.code == gpm_pkg::C_PWR)
			begin
				if (a0 == gpm_pkg::PM_FULL && exit_ok)
				begin
					n.mode = gpm_pkg::M_FULL;
					n.tmr = 20'h00000;
				end
				else if (s.mode == gpm_pkg::M_FULL)
				begin
					if (a0 == gpm_pkg::PM_PBK || a0 == gpm_pkg::PM_PSB)
					begin
						n.mode = gpm_pkg::M_PDLY;
						n.tmr = gpm_pkg::PER_DLY_MS;
						n.pbk = (a0 == gpm_pkg::PM_PBK);
						n.ext = 1'b0;
						n.run = s.arg[1];
						n.slp = s.arg[2];
						n.erun = s.arg[3];
						n.eslp = s.arg[4];
					end
					else if (a0 == gpm_pkg::PM_ASB || a0 == gpm_pkg::PM_ABK)
					begin
						n.mode = gpm_pkg::M_AON;
						n.tmr = gpm_pkg::AD_ON_MS;
						n.pbk = (a0 == gpm_pkg::PM_ABK);
						if (a0 == gpm_pkg::PM_ASB && !s.tx_act)
						begin
							n.tx_act = 1'b1;
							n.tx_idx = 5'h00;
							n.tx_ck = 8'h00;
						end
					end
				end
			end
			else if (s.code == gpm_pkg::C_FIT)
			begin
				if (a0 == 20'h00001)
				begin
					n.fit_arm = 1'b1;
					n.orb_en = 1'b0;
				end
				else if (a0 == 20'h00000)
				begin
					n.fit_arm = 1'b0;
					n.fit_act = 1'b0;
					n.fit_ms = 16'h0000;
				end
			end
			else if (s.code == gpm_pkg::C_ORB)
			begin
				if (a0 == 20'h00001 && !s.fit_arm)
					n.orb_en = (s.arg[1] != 20'h00000);
			end
			else if (s.code == gpm_pkg::C_AIC)
			begin
				if (a0 == 20'h00001)
					n.interference_cancellation = 1'b1;
				else if (a0 == 20'h00000)
					n.interference_cancellation = 1'b0;
			end
		end

		// transmitter and acknowledgement sequencer
		if (s.tx_busy)
		begin
			if (s.tx_cnt != 16'h0000)
				n.tx_cnt = s.tx_cnt - 16'h0001;
			else
			begin
				n.tx_cnt = div - 16'h0001;
				if (s.tx_bit == 4'h9)
					n.tx_busy = 1'b0;
				else
				begin
					n.txd = s.tx_sh[0];
					n.tx_sh = {1'b1, s.tx_sh[8:1]};
					n.tx_bit = s.tx_bit + 4'h1;
				end
			end
		end
		else if (s.tx_act)
		begin
			n.tx_busy = 1'b1;
			n.txd = 1'b0;
			n.tx_cnt = div - 16'h0001;
			n.tx_bit = 4'h0;
			n.tx_sh = {1'b1, tb};
			n.tx_idx = s.tx_idx + 5'h01;
			// checksum stops before the asterisk at index 14
			if (s.tx_idx != 5'h00 && s.tx_idx < 5'h0E)
				n.tx_ck = s.tx_ck ^ tb;
			if (s.tx_idx == gpm_pkg::ACK_LAST)
				n.tx_act = 1'b0;
		end

		// derived outputs
		n.rf_on = (n.mode != gpm_pkg::M_PSLP) && (n.mode != gpm_pkg::M_AOFF);
		n.nmea = n.rf_on;
		n.psw = n.pbk && !n.rf_on;

		// apb slave, one wait state
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !s.pready)
		begin
			n.pready = 1'b1;
			case (paddr)
				gpm_pkg::R_CTRL:
					n.prdata = {29'h0, s.baud};
				gpm_pkg::R_STAT:
					n.prdata = {16'h0000, gpm_pkg::AIC_TONES, s.psw_sync[1],
						s.ext, s.fit_act, s.fit_arm, s.interference_cancellation, s.orb_rdy,
						s.orb_en, fix_valid, s.mode};
				gpm_pkg::R_CMD:
					n.prdata = {s.last_arg, 6'h00, s.last_code};
				default:
				begin
					n.prdata = 32'h0000_0000;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s.pready && pwrite && paddr == gpm_pkg::R_CTRL
			&& pwdata[2:0] <= gpm_pkg::BAUD_MAX)
			n.baud = pwdata[2:0];
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.baud <= gpm_pkg::BAUD_RST;
			s.orb_en <= 1'b1;
			s.interference_cancellation <= 1'b1;
			s.txd <= 1'b1;
			s.rx_sync <= 2'h3;
			s.rf_on <= 1'b1;
			s.nmea <= 1'b1;
		end
		else
			s <= n;
	end

	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign prdata = s.prdata;
	assign uart_txd = s.txd;
	assign pwr_sw_out = 1'b0;
	assign pwr_sw_oe = s.psw;
	assign rf_on = s.rf_on;
	assign nmea_en = s.nmea;
	assign orbit_predict_en = s.orb_en;
	assign interference_cancellation_en = s.interference_cancellation;
	assign fitness_duty_cycle_mode = s.fit_act;
	assign orbit_ready = s.orb_rdy;

endmodule : gpm_ctrl

// [verification/gpm_ctrl_chk.sv]
// checker: concurrent assertions on the controller's ports
module gpm_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// serial and switch
	input wire logic uart_txd,
	input wire logic pwr_sw_out,
	input wire logic pwr_sw_oe,
	// status and enables
	input wire logic fix_valid,
	input wire logic rtc_valid,
	input wire logic rf_on,
	input wire logic nmea_en,
	input wire logic orbit_predict_en,
	input wire logic fitness_duty_cycle_mode,
	input wire logic orbit_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// shortest bit time; every supported bit time is a multiple of it
	localparam int BIT_MIN = 434;

	logic [16:0] low_len;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// helper: length of the current low run on the serial output
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_len <= 17'h00000;
		else if (!uart_txd)
			low_len <= low_len + 17'h00001;
		else
			low_len <= 17'h00000;
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer missing after one wait state");
	AST_APB_ONE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_ERR_PAIR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_NMEA_OFF: assert property (!rf_on |-> !nmea_en)
		else $error("nmea output while radio is off");
	AST_FIT_ORB: assert property (fitness_duty_cycle_mode |-> !orbit_predict_en)
		else $error("fitness mode together with orbit prediction");
	AST_FIT_FIX: assert property ($rose(fitness_duty_cycle_mode) |-> $past(fix_valid))
		else $error("fitness mode entered without a fix");
	AST_ORB_RTC: assert property ($rose(orbit_ready) |-> $past(rtc_valid))
		else $error("orbit data ready without valid time");
	AST_PSW_SLEEP: assert property (pwr_sw_oe |-> !rf_on && !pwr_sw_out)
		else $error("power switch pulled outside backup sleep");
	AST_TX_BIT: assert property ($rose(uart_txd) |-> low_len != 17'h00000 && low_len % BIT_MIN == 0)
		else $error("serial low run not a whole number of bits");
endmodule : gpm_chk

bind gpm_ctrl gpm_chk CHK (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .uart_txd, .pwr_sw_out, .pwr_sw_oe, .fix_valid, .rtc_valid,
	.rf_on, .nmea_en, .orbit_predict_en, .fitness_duty_cycle_mode,
	.orbit_ready);

// [verification/gpm_host.sv]
// partner: host terminal sending checksummed commands, collecting replies
module gpm_host #(
	parameter int BIT_CYC = 434
) (
	// clock
	input wire logic pclk,
	// serial lines
	input wire logic uart_txd,
	output logic     uart_rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] rxq[$];

	initial uart_rxd = 1'b1;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] cks(input string s);
		logic [7:0] c;
		c = 8'h00;
		foreach (s[i])
			c = c ^ 8'(s[i]);
		return c;
	endfunction : cks

	function automatic logic [7:0] hexc(input logic [3:0] v);
		return (v < 4'hA) ? 8'(8'h30 + v) : 8'(8'h37 + v);
	endfunction : hexc

	// 8N1, lsb first, no handshake lines
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			uart_rxd <= f[i];
			repeat (BIT_CYC) @(posedge pclk);
		end
	endtask : put_byte

	// bad inverts the checksum so the sentence must be dropped
	task automatic send_cmd(input string body, input logic bad);
		logic [7:0] c;
		c = cks(body) ^ {8{bad}};
		@(posedge pclk);
		put_byte(8'h24);
		foreach (body[i])
			put_byte(8'(body[i]));
		put_byte(8'h2A);
		put_byte(hexc(c[7:4]));
		put_byte(hexc(c[3:0]));
	endtask : send_cmd

	// ****************************************************************
	// receiver: samples mid-bit
	// ****************************************************************
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(negedge uart_txd);
			repeat (BIT_CYC / 2) @(posedge pclk);
			if (!uart_txd)
			begin
				for (int i = 0; i < 8; i++)
				begin
					repeat (BIT_CYC) @(posedge pclk);
					b[i] = uart_txd;
				end
				rxq.push_back(b);
				repeat (BIT_CYC) @(posedge pclk);
			end
		end
	end
endmodule : gpm_host

// [verification/gpm_ctrl_tb.sv]
// testbench: register access, command handling and reply of the controller
module gpm_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        pready, pslverr, rerr;
	logic        uart_rxd, uart_txd, pwr_sw_in, pwr_sw_out, pwr_sw_oe;
	logic        fix_valid, rtc_valid, rf_on, nmea_en;
	logic        orb_en, aic_en, fit, orb_rdy;
	int          err_total, checked;

	// pull-up on the open-drain switch line
	assign pwr_sw_in = pwr_sw_oe ? 1'b0 : 1'b1;

	gpm_ctrl #(.MS_CYCLES(50)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .uart_rxd(uart_rxd), .uart_txd(uart_txd),
		.pwr_sw_in(pwr_sw_in), .pwr_sw_out(pwr_sw_out),
		.pwr_sw_oe(pwr_sw_oe), .fix_valid(fix_valid),
		.rtc_valid(rtc_valid), .rf_on(rf_on), .nmea_en(nmea_en),
		.orbit_predict_en(orb_en), .interference_cancellation_en(aic_en),
		.fitness_duty_cycle_mode(fit), .orbit_ready(orb_rdy));

	gpm_host #(.BIT_CYC(434)) HOST (.pclk(pclk), .uart_txd(uart_txd),
		.uart_rxd(uart_rxd));

	// ****************************************************************
	// common tasks
	// ****************************************************************
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready is sampled at the rising edge; release at that same edge
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			err_total++;
			close_out();
		end
	endtask : apb

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		chk(32'({orb_en, aic_en, fit, rf_on, nmea_en}), 32'h1B);
		chk(32'({pwr_sw_oe, pwr_sw_out, orb_rdy}), 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rdata, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rdata & 32'h0000FBAF, 32'h0000C8A0);
	endtask : t_reset

	task automatic t_unmap;
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk(32'(rerr), 32'h1);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdata, 32'h0);
		chk(32'(rerr), 32'h1);
	endtask : t_unmap

	task automatic t_baud;
		for (int v = 0; v < 8; v++)
		begin
			apb(1'b1, 12'h000, 32'(v));
			apb(1'b0, 12'h000, 32'h0);
			chk(rdata, (v > 6) ? 32'h6 : 32'(v));
		end
	endtask : t_baud

	task automatic t_adapt;
		fix_valid <= 1'b1;
		HOST.send_cmd("225,8", 1'b0);
		repeat (20) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rdata & 32'hF, 32'h4);
		apb(1'b0, 12'h008, 32'h0);
		chk(rdata, 32'h000800E1);
		chk(32'(rf_on), 32'h1);
		chk(32'({pwr_sw_oe, pwr_sw_out}), 32'h0);
	endtask : t_adapt

	task automatic t_badck;
		HOST.send_cmd("225,0", 1'b1);
		repeat (20) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rdata & 32'hF, 32'h4);
		apb(1'b0, 12'h008, 32'h0);
		chk(rdata, 32'h000800E1);
	endtask : t_badck

	task automatic t_exit;
		HOST.send_cmd("225,0", 1'b0);
		repeat (20) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rdata & 32'hF, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk(rdata, 32'h000000E1);
	endtask : t_exit

	task automatic t_ack;
		string      s;
		logic [7:0] c;
		logic [7:0] e[19];
		int         n;
		s = "$PACK001,225,3*";
		c = HOST.cks("PACK001,225,3");
		foreach (s[i])
			e[i] = 8'(s[i]);
		e[15] = HOST.hexc(c[7:4]);
		e[16] = HOST.hexc(c[3:0]);
		e[17] = 8'h0D;
		e[18] = 8'h0A;
		n = 0;
		while (HOST.rxq.size() < 19 && n < 100000)
		begin
			@(posedge pclk);
			n++;
		end
		chk(32'(HOST.rxq.size()), 32'd19);
		for (int i = 0; i < 19 && i < HOST.rxq.size(); i++)
			chk(32'(HOST.rxq[i]), 32'(e[i]));
	endtask : t_ack

	// ****************************************************************
	// clock, watchdog and main sequence
	// ****************************************************************
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial
	begin
		repeat (150000) @(posedge pclk);
		err_total++;
		close_out();
	end

	initial
	begin
		err_total = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fix_valid = 1'b0;
		rtc_valid = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_unmap();
		t_baud();
		t_adapt();
		t_badck();
		t_exit();
		t_ack();
		close_out();
	end
endmodule : gpm_ctrl_tb
